// ==== break_bus_if.sv ====
`timescale 1ns/1ns
`default_nettype none

// Shared bus between a break channel and the processor; other_req stands
// for the priority bits of further channels and is driven by the bench.
interface break_bus_if;
  logic [11:0] chan_req;
  logic [11:0] other_req;
  logic [11:0] bus_req;
  logic break_grant;
  logic major_state_disable;
  logic [11:0] xfer_addr;
  data_break_pkg::xfer_mode_t xfer_mode;
  logic [11:0] data_to_mem;
  logic fourth_time_state;
  logic cycle_end;
  logic dma_cycle;
  logic mem_done;
  logic [11:0] data_from_mem;

  // Wired view of all priority bits on the data lines.
  assign bus_req = chan_req | other_req;

  modport channel_end (
    output chan_req, break_grant, major_state_disable, xfer_addr, xfer_mode, data_to_mem,
    input bus_req, fourth_time_state, cycle_end, dma_cycle, mem_done, data_from_mem
  );

  modport processor_end (
    input bus_req, break_grant, major_state_disable, xfer_addr, xfer_mode, data_to_mem,
    output fourth_time_state, cycle_end, dma_cycle, mem_done, data_from_mem
  );
endinterface

`default_nettype wire

// ==== break_bus_props.sv ====
`timescale 1ns/1ns
`default_nettype none

// Watches the shared break bus where channel and processor meet.
module break_bus_props (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [11:0] chan_req,
  input wire logic [11:0] bus_req,
  input wire logic break_grant,
  input wire logic major_state_disable,
  input wire logic [11:0] xfer_addr,
  input wire data_break_pkg::xfer_mode_t xfer_mode,
  input wire logic fourth_time_state,
  input wire logic cycle_end,
  input wire logic dma_cycle,
  input wire logic mem_done
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // The clock on which the channel takes the bus.
  sequence s_win;
    $rose(break_grant);
  endsequence

  // The grant is seen by the processor at the close of a machine cycle.
  sequence s_taken;
    cycle_end && break_grant;
  endsequence

  // A lineless channel has chan_req zero, so the mask covers every line and any bit blocks it.
  a_grant_pair: assert property (break_grant == major_state_disable)
    else $error("grant and state disable differ");
  a_one_line: assert property ($onehot0(chan_req))
    else $error("more than one priority line driven");
  a_win_clear: assert property (s_win |-> $past(fourth_time_state)
    && $past(((chan_req - 12'h001) & bus_req) == 12'h000))
    else $error("grant taken outside the fourth state or over a higher line");
  a_win_ends: assert property (s_win |-> ##[1:40] mem_done)
    else $error("granted word never completed");
  a_grant_stands: assert property (s_win |=> break_grant until mem_done)
    else $error("grant dropped before the memory operation");
  a_break_follows: assert property (s_taken |=> dma_cycle)
    else $error("break cycle did not follow the requesting cycle");
  a_done_in_dma: assert property (mem_done |-> dma_cycle && break_grant)
    else $error("memory operation outside a granted break cycle");
  a_grant_release: assert property (mem_done |-> ##[1:2] !break_grant)
    else $error("processor not given back after the word");
  a_addr_steady: assert property (break_grant && $past(break_grant) |->
    $stable(xfer_addr) && $stable(xfer_mode))
    else $error("address or mode moved during a break");
endmodule

`default_nettype wire

// ==== break_channel.sv ====
// The Avalon-MM register port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "data_break_defines.svh"

// Behaviour
// - Pre-increment 12-bit address, use new value
// - Block moves up to 4096 consecutive words
// - 12-bit counter holds negative remaining words
// - Counter increments; zero marks final word
// - Overflow clears enable, stops requests
// - Up to 12 channels, one line each
// - Line zero highest, line eleven lowest
// - Higher line transfers first on collision
// - Extra lineless channel is always lowest
// - Drive own line, check higher lines
// - Unblocked by fourth state: assert two signals
// - Processor routes bus through its adder
// - Output: memory word into data register
// - Input: data register written to memory
// - Add mode writes sum back
// - Transfer follows the requesting machine cycle
// - Lower request served once processor freed
// - Processor registers kept, execution resumes
// - One machine cycle per word, counters updated
// - After final word: clear enable, set done
module break_channel (
  input wire logic ref_clk,
  input wire logic rst_n,
  break_bus_if.channel_end bus,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic word_strobe,
  input wire logic [11:0] word_in,
  output logic [11:0] word_out,
  output logic word_out_strobe,
  output logic busy,
  output logic done_flag
);
  data_break_pkg::chan_state_t st_q, st_d;
  data_break_pkg::xfer_mode_t mode_q;
  logic [11:0] current_address_q, word_counter_q, data_q, addr_q, req_q, out_q;
  logic [11:0] higher_mask, next_wc;
  logic [3:0] prio_q;
  logic en_q, done_q, last_q, grant_q, busy_q, out_stb_q, wait_q;
  logic [31:0] rdata_q;
  logic blocked, win, take, finish, wr_fire;

  // Lines with a lower index than ours outrank us; no line means all do.
  for (genvar i = 0; i < `DB_LINES; i++) begin : g_mask
    assign higher_mask[i] = (4'(i) < prio_q);
  end

  assign next_wc = word_counter_q + `DB_WORD_ONE;
  assign blocked = |(bus.bus_req & higher_mask);
  // The last clock of the fourth state is skipped: the processor samples the grant then.
  assign win = (st_q == data_break_pkg::CH_REQ) && en_q && bus.fourth_time_state &&
               !bus.cycle_end && !blocked;
  assign take = (st_q == data_break_pkg::CH_IDLE) && en_q && word_strobe;
  assign finish = (st_q == data_break_pkg::CH_OWN) && bus.mem_done;
  assign wr_fire = avs_write && !wait_q;

  // Next channel state; a losing request simply retries next cycle.
  always_comb begin
    st_d = st_q;
    case (st_q)
      data_break_pkg::CH_IDLE: begin
        if (take) begin
          st_d = data_break_pkg::CH_REQ;
        end
      end
      data_break_pkg::CH_REQ: begin
        if (!en_q) begin
          st_d = data_break_pkg::CH_IDLE;
        end else if (win) begin
          st_d = data_break_pkg::CH_OWN;
        end
      end
      data_break_pkg::CH_OWN: begin
        if (finish) begin
          st_d = data_break_pkg::CH_IDLE;
        end
      end
      default: st_d = data_break_pkg::CH_IDLE;
    endcase
  end

  // State register and busy indication.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= data_break_pkg::CH_IDLE;
      busy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      busy_q <= (st_d != data_break_pkg::CH_IDLE);
    end
  end

  // Address and counter step together when the cycle is won.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      current_address_q <= `DB_WORD_ZERO;
      word_counter_q <= `DB_WORD_ZERO;
      addr_q <= `DB_WORD_ZERO;
      last_q <= 1'b0;
    end else if (win) begin
      current_address_q <= current_address_q + `DB_WORD_ONE;
      addr_q <= current_address_q + `DB_WORD_ONE;
      word_counter_q <= next_wc;
      last_q <= (next_wc == `DB_WORD_ZERO);
    end else if (wr_fire && avs_address == `DB_REG_CA) begin
      current_address_q <= avs_writedata[11:0];
    end else if (wr_fire && avs_address == `DB_REG_WC) begin
      word_counter_q <= avs_writedata[11:0];
    end
  end

  // Control register; overflow clearing the enable beats a software write.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= 1'b0;
      mode_q <= data_break_pkg::XFER_OUT;
      prio_q <= `DB_RESET_CTRL;
    end else if (finish && last_q) begin
      en_q <= 1'b0;
    end else if (wr_fire && avs_address == `DB_REG_CTRL) begin
      en_q <= avs_writedata[`DB_CTRL_EN];
      mode_q <= data_break_pkg::xfer_mode_t'(avs_writedata[`DB_CTRL_MODE_HI:`DB_CTRL_MODE_LO]);
      prio_q <= avs_writedata[`DB_CTRL_PRIO_HI:`DB_CTRL_PRIO_LO];
    end
  end

  // Completion flag: write one to clear, a simultaneous completion wins.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else if (finish && last_q) begin
      done_q <= 1'b1;
    end else if (wr_fire && avs_address == `DB_REG_STATUS && avs_writedata[`DB_ST_DONE]) begin
      done_q <= 1'b0;
    end
  end

  // Data register: peripheral word for input and add, memory word for output.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_q <= `DB_WORD_ZERO;
    end else if (take && mode_q != data_break_pkg::XFER_OUT) begin
      data_q <= word_in;
    end else if (finish && mode_q == data_break_pkg::XFER_OUT) begin
      data_q <= bus.data_from_mem;
    end else if (wr_fire && avs_address == `DB_REG_DATA) begin
      data_q <= avs_writedata[11:0];
    end
  end

  // Priority bit and the two grant signals on the bus.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_q <= `DB_WORD_ZERO;
      grant_q <= 1'b0;
    end else begin
      if (st_d == data_break_pkg::CH_REQ && prio_q < `DB_NO_LINE) begin
        req_q <= `DB_WORD_ONE << prio_q;
      end else begin
        req_q <= `DB_WORD_ZERO;
      end
      if (win) begin
        grant_q <= 1'b1;
      end else if (finish) begin
        grant_q <= 1'b0;
      end
    end
  end

  // Word handed to the peripheral after an output transfer.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= `DB_WORD_ZERO;
      out_stb_q <= 1'b0;
    end else begin
      out_stb_q <= finish && (mode_q == data_break_pkg::XFER_OUT);
      if (finish && mode_q == data_break_pkg::XFER_OUT) begin
        out_q <= bus.data_from_mem;
      end
    end
  end

  // Avalon slave: one wait state, read data captured in it.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= !((avs_read || avs_write) && wait_q);
      if (avs_read && wait_q) begin
        case (avs_address)
          `DB_REG_CA: rdata_q <= {20'h00000, current_address_q};
          `DB_REG_WC: rdata_q <= {20'h00000, word_counter_q};
          `DB_REG_CTRL: rdata_q <= {24'h000000, prio_q, 1'b0, mode_q, en_q};
          `DB_REG_STATUS: rdata_q <= {28'h0000000, last_q, busy_q, en_q, done_q};
          `DB_REG_DATA: rdata_q <= {20'h00000, data_q};
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign bus.chan_req = req_q;
  assign bus.break_grant = grant_q;
  assign bus.major_state_disable = grant_q;
  assign bus.xfer_addr = addr_q;
  assign bus.xfer_mode = mode_q;
  assign bus.data_to_mem = data_q;
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign word_out = out_q;
  assign word_out_strobe = out_stb_q;
  assign busy = busy_q;
  assign done_flag = done_q;
endmodule

`default_nettype wire

// ==== break_processor.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "data_break_defines.svh"

// Processor and memory end: times the machine cycle and serves break cycles.
module break_processor #(
  parameter int unsigned TS_CLKS = `DB_TS_CLKS
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  break_bus_if.processor_end bus,
  input wire logic host_wr,
  input wire logic [11:0] host_addr,
  input wire logic [11:0] host_wdata,
  output logic [11:0] host_rdata,
  output logic frozen,
  output logic [15:0] prog_cycles
);
  logic [11:0] mem [0:4095];
  logic [7:0] cnt_q;
  logic last_q;
  data_break_pkg::time_state_t ts_q;
  logic ts4_q, end_q, dma_q, done_q;
  logic [11:0] rd_q, hrd_q;
  logic [15:0] prog_q;
  logic mem_slot;

  // Memory is touched at the last clock of the third time state.
  assign mem_slot = dma_q && last_q && (ts_q == data_break_pkg::TS3);

  // Divider: last_q marks the final clock of each time state.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
      last_q <= 1'b0;
    end else if (last_q) begin
      cnt_q <= 8'h00;
      last_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      last_q <= (cnt_q == 8'(TS_CLKS - 2));
    end
  end

  // Time-state sequence with the fourth-state level and cycle-end pulse.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ts_q <= data_break_pkg::TS1;
      ts4_q <= 1'b0;
      end_q <= 1'b0;
    end else begin
      end_q <= !last_q && (ts_q == data_break_pkg::TS4) && (cnt_q == 8'(TS_CLKS - 2));
      if (last_q) begin
        case (ts_q)
          data_break_pkg::TS1: ts_q <= data_break_pkg::TS2;
          data_break_pkg::TS2: ts_q <= data_break_pkg::TS3;
          data_break_pkg::TS3: ts_q <= data_break_pkg::TS4;
          default: ts_q <= data_break_pkg::TS1;
        endcase
        ts4_q <= (ts_q == data_break_pkg::TS3);
      end
    end
  end

  // A grant seen at cycle end makes the next cycle a break cycle.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_q <= 1'b0;
    end else if (end_q) begin
      dma_q <= bus.break_grant && bus.major_state_disable;
    end
  end

  // Program cycles advance only outside break cycles, so state resumes.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_q <= 16'h0000;
    end else if (end_q && !dma_q) begin
      prog_q <= prog_q + 16'h0001;
    end
  end

  // Break memory access through the adder path; a host write the same clock loses.
  always_ff @(posedge ref_clk) begin
    if (mem_slot) begin
      case (bus.xfer_mode)
        data_break_pkg::XFER_IN: mem[bus.xfer_addr] <= bus.data_to_mem;
        data_break_pkg::ADD_TO_MEMORY_OP: mem[bus.xfer_addr] <= mem[bus.xfer_addr] + bus.data_to_mem;
        default: ;
      endcase
    end else if (host_wr) begin
      mem[host_addr] <= host_wdata;
    end
    hrd_q <= mem[host_addr];
  end

  // Read data and completion pulse towards the channel.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= `DB_WORD_ZERO;
      done_q <= 1'b0;
    end else begin
      done_q <= mem_slot;
      if (mem_slot) begin
        if (bus.xfer_mode == data_break_pkg::ADD_TO_MEMORY_OP) begin
          rd_q <= mem[bus.xfer_addr] + bus.data_to_mem;
        end else begin
          rd_q <= mem[bus.xfer_addr];
        end
      end
    end
  end

  assign bus.fourth_time_state = ts4_q;
  assign bus.cycle_end = end_q;
  assign bus.dma_cycle = dma_q;
  assign bus.mem_done = done_q;
  assign bus.data_from_mem = rd_q;
  assign host_rdata = hrd_q;
  assign frozen = dma_q;
  assign prog_cycles = prog_q;
endmodule

`default_nettype wire

// ==== data_break_channel_bench.sv ====
`timescale 1ns/1ns
`default_nettype none

// Joins channel and processor and checks blocks, registers and priority.
module data_break_channel_bench;
  localparam int LIMIT = 5000;
  localparam logic [3:0] LINE_TAB [3] = '{4'h5, 4'h5, 4'hC};
  localparam logic [11:0] OTHER_TAB [3] = '{12'h010, 12'h040, 12'h800};
  localparam logic WAIT_TAB [3] = '{1'b1, 1'b0, 1'b1};
  logic ref_clk, rst_n, avs_read, avs_write, avs_waitrequest, word_strobe, done_flag, host_wr;
  logic [2:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [11:0] word_in, word_out, host_addr, host_wdata, host_rdata;
  logic word_out_strobe, busy, frozen;
  logic [15:0] prog_cycles;
  logic [11:0] exp_mem [4096];
  logic [15:0] seed;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int n_out = 0;
  int n_frozen = 0;

  break_bus_if bus_inst ();
  break_channel break_channel_inst (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus_inst.channel_end),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .word_strobe(word_strobe), .word_in(word_in),
    .word_out(word_out), .word_out_strobe(word_out_strobe), .busy(busy),
    .done_flag(done_flag));
  // Two clocks per time state keeps each machine cycle at eight clocks.
  break_processor #(.TS_CLKS(2)) break_processor_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .bus(bus_inst.processor_end), .host_wr(host_wr), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .frozen(frozen),
    .prog_cycles(prog_cycles));
  break_bus_props props_inst (.ref_clk(ref_clk), .rst_n(rst_n), .chan_req(bus_inst.chan_req),
    .bus_req(bus_inst.bus_req), .break_grant(bus_inst.break_grant),
    .major_state_disable(bus_inst.major_state_disable), .xfer_addr(bus_inst.xfer_addr),
    .xfer_mode(bus_inst.xfer_mode), .fourth_time_state(bus_inst.fourth_time_state),
    .cycle_end(bus_inst.cycle_end), .dma_cycle(bus_inst.dma_cycle),
    .mem_done(bus_inst.mem_done));

  // Free-running clock.
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Shift register source of repeatable stimulus.
  function automatic logic [11:0] rand12();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[11:0];
  endfunction

  // Memory word after a transfer of the given kind; the add wraps at twelve bits.
  function automatic logic [11:0] exp_word(input int m, input logic [11:0] old,
                                           input logic [11:0] d);
    return (m == 0) ? old : ((m == 1) ? d : old + d);
  endfunction

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    if (num_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One Avalon transfer; the request is held until waitrequest is sampled low.
  task automatic av(input logic [2:0] adr, input logic wr, input logic [31:0] wd,
                    output logic [31:0] rd);
    avs_address <= adr;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic host_put(input logic [11:0] a, input logic [11:0] d);
    host_addr <= a;
    host_wdata <= d;
    host_wr <= 1'b1;
    @(posedge ref_clk);
    host_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic mem_chk(input logic [11:0] a);
    host_addr <= a;
    repeat (2) @(posedge ref_clk);
    chk_word({20'h0, host_rdata}, {20'h0, exp_mem[a]});
  endtask

  // Offers one word and waits, bounded, for its memory operation.
  task automatic word_go(input logic [11:0] d);
    int n;
    word_in <= d;
    word_strobe <= 1'b1;
    @(posedge ref_clk);
    word_strobe <= 1'b0;
    for (n = 0; n < 40 && bus_inst.mem_done !== 1'b1; n++) @(posedge ref_clk);
    repeat (4) @(posedge ref_clk);
  endtask

  // Offers one word and watches exactly forty clocks, which is five machine cycles
  // wherever the window starts, so a break must cost the program one cycle only.
  task automatic window_chk(input logic en, input logic [11:0] d);
    logic [15:0] p0;
    int o0, f0;
    p0 = prog_cycles;
    o0 = n_out;
    f0 = n_frozen;
    word_in <= d;
    word_strobe <= 1'b1;
    @(posedge ref_clk);
    word_strobe <= 1'b0;
    @(posedge ref_clk);
    chk_flag(busy, en);
    repeat (38) @(posedge ref_clk);
    chk_word({16'h0, prog_cycles - p0}, en ? 32'h4 : 32'h5);
    chk_word(n_frozen - f0, en ? 32'h8 : 32'h0);
    chk_word(n_out - o0, {31'h0, en});
    chk_flag(busy, 1'b0);
  endtask

  // A hang counts as a mismatch and ends the run.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      num_errors++;
      conclude();
    end
  end

  // Output strobes and break-cycle clocks, counted for the window checks.
  always @(posedge ref_clk) begin
    n_out <= n_out + int'(word_out_strobe);
    n_frozen <= n_frozen + int'(frozen);
  end

  initial begin
    int m, i, k;
    logic [11:0] start, a, d, ca0;
    {avs_read, avs_write, word_strobe, host_wr} = 4'h0;
    avs_address = 3'h0;
    avs_writedata = 32'h0;
    word_in = 12'h000;
    host_addr = 12'h000;
    host_wdata = 12'h000;
    bus_inst.other_req = 12'h000;
    seed = 16'h0001;
    rst_n = 1'b0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    av(3'h2, 1'b0, 32'h0, q);
    chk_word(q, 32'h0);
    av(3'h5, 1'b1, 32'h0000_0ABC, q);
    av(3'h5, 1'b0, 32'h0, q);
    chk_word(q, 32'h0);
    // Three-word block in each mode; the first starts at the top and wraps to zero.
    for (m = 0; m < 3; m++) begin
      start = (m == 0) ? 12'h000 : rand12();
      for (i = 0; i < 3; i++) begin
        a = start + 12'(i);
        exp_mem[a] = rand12();
        host_put(a, exp_mem[a]);
      end
      av(3'h0, 1'b1, 32'hFFFF_F000 | {20'h0, start - 12'h001}, q);
      av(3'h0, 1'b0, 32'h0, q);
      chk_word(q, {20'h0, start - 12'h001});
      av(3'h1, 1'b1, 32'h0000_0FFD, q);
      av(3'h2, 1'b1, {28'h0, 2'(m), 1'b0} | 32'h1, q);
      for (i = 0; i < 3; i++) begin
        a = start + 12'(i);
        d = rand12();
        word_go(d);
        exp_mem[a] = exp_word(m, exp_mem[a], d);
        if (m == 0) chk_word({20'h0, word_out}, {20'h0, exp_mem[a]});
      end
      chk_flag(done_flag, 1'b1);
      av(3'h4, 1'b0, 32'h0, q);
      chk_word(q, {20'h0, (m == 0) ? exp_mem[a] : d});
      av(3'h3, 1'b0, 32'h0, q);
      chk_word(q & 32'h3, 32'h1);
      av(3'h1, 1'b0, 32'h0, q);
      chk_word(q, 32'h0);
      word_go(rand12());
      av(3'h0, 1'b0, 32'h0, q);
      chk_word(q, {20'h0, start + 12'h002});
      for (i = 0; i < 3; i++) mem_chk(start + 12'(i));
      av(3'h3, 1'b1, 32'h1, q);
      chk_flag(done_flag, 1'b0);
    end
    // Requests on other lines either hold the channel off or do not.
    for (k = 0; k < 3; k++) begin
      av(3'h1, 1'b1, 32'h0000_0F00, q);
      av(3'h2, 1'b1, {24'h0, LINE_TAB[k], 4'h1}, q);
      av(3'h0, 1'b0, 32'h0, q);
      ca0 = q[11:0];
      bus_inst.other_req <= OTHER_TAB[k];
      @(posedge ref_clk);
      word_go(rand12());
      av(3'h0, 1'b0, 32'h0, q);
      chk_word(q, {20'h0, ca0 + {11'h0, !WAIT_TAB[k]}});
      bus_inst.other_req <= 12'h000;
      @(posedge ref_clk);
      for (i = 0; i < 40 && bus_inst.mem_done !== 1'b1; i++) @(posedge ref_clk);
      repeat (4) @(posedge ref_clk);
      av(3'h0, 1'b0, 32'h0, q);
      chk_word(q, {20'h0, ca0 + 12'h001});
    end
    // One machine cycle lent per word on the top line, none while disabled.
    av(3'h2, 1'b1, 32'h0000_0001, q);
    window_chk(1'b1, rand12());
    av(3'h2, 1'b1, 32'h0000_0000, q);
    window_chk(1'b0, rand12());
    // A reset in mid-run must bring every register back to zero.
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    for (i = 0; i < 5; i++) begin
      av(3'(i), 1'b0, 32'h0, q);
      chk_word(q, 32'h0);
    end
    conclude();
  end
endmodule

`default_nettype wire

// ==== data_break_defines.svh ====
`ifndef DATA_BREAK_DEFINES_SVH
`define DATA_BREAK_DEFINES_SVH

// Register word indices on the channel's Avalon-MM slave.
`define DB_REG_CA 3'h0
`define DB_REG_WC 3'h1
`define DB_REG_CTRL 3'h2
`define DB_REG_STATUS 3'h3
`define DB_REG_DATA 3'h4

// Control register fields.
`define DB_CTRL_EN 0
`define DB_CTRL_MODE_LO 1
`define DB_CTRL_MODE_HI 2
`define DB_CTRL_PRIO_LO 4
`define DB_CTRL_PRIO_HI 7

// Status register fields.
`define DB_ST_DONE 0
`define DB_ST_EN 1
`define DB_ST_BUSY 2
`define DB_ST_LAST 3

// Priority lines on the data bus; a line select of 12 means no line.
`define DB_LINES 12
`define DB_NO_LINE 4'hC

// Word constants and reset values.
`define DB_WORD_ZERO 12'h000
`define DB_WORD_ONE 12'h001
`define DB_RESET_CTRL 4'h0

// Time-state length in ns and the clock period in ns.
`define DB_CLK_NS 100
`define DB_TS_NS 300
`define DB_TS_CLKS ((`DB_TS_NS) / (`DB_CLK_NS))

`endif

// ==== data_break_pkg.sv ====
`default_nettype none

package data_break_pkg;

  // Kind of memory operation the channel asks for.
  typedef enum logic [1:0] {
    XFER_OUT = 2'h0,
    XFER_IN = 2'h1,
    ADD_TO_MEMORY_OP = 2'h2
  } xfer_mode_t;

  // Channel sequence.
  typedef enum logic [2:0] {
    CH_IDLE = 3'h1,
    CH_REQ = 3'h2,
    CH_OWN = 3'h4
  } chan_state_t;

  // Processor time states within one machine cycle.
  typedef enum logic [3:0] {
    TS1 = 4'h1,
    TS2 = 4'h2,
    TS3 = 4'h4,
    TS4 = 4'h8
  } time_state_t;

endpackage

`default_nettype wire
